// ===== verilog/adcsf_frame.v
// Serial frame timing of the converter: decimation, output frames, frame-sync input, APB
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "adcsf_map.vh"
// Notes on behaviour
// R1 - Host supplies master clock, 500 kHz-40 MHz
// R2 - Modulator clock is master clock halved
// R3 - One output word per decimation period
// R4 - Frame-sync out falls after serial clock rise
// R5 - Data driver enabled on frame-sync fall
// R6 - First bit out is the MSB
// R7 - Next bit after each serial clock rise
// R8 - Frame-sync out rises; low 32 periods max
// R9 - Frame-sync in sampled on serial falls
// R10 - Host holds frame-sync in 1..32 periods
// R11 - Host holds reset low one clock minimum
// R12 - Reset release registered on master clock rise
// R13 - Host holds sync low four clocks minimum
// R14 - Sync rise registered on master clock fall
// R15 - Low sleep pin stops conversions and frames
// R16 - Data output undriven between frames
// R17 - Reset restarts decimation and framing
module adcsf_frame #(
	parameter WORD_W = 32
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sleep_pin_n,
	input  wire        sync_n,
	input  wire        frame_sync_in,
	input  wire        serial_data_in,
	output wire        modulator_clock,
	output wire        serial_clock_out,
	output reg         frame_sync_out,
	output wire        serial_data_out,
	output wire        serial_data_out_oe,
	output reg         sync_done
);
	reg  [2:0]        ctrl;
	reg  [WORD_W-1:0] conv_word;
	reg  [WORD_W-1:0] fsi_word;
	reg               word_ready;
	reg               fsi_rx;
	reg  [9:0]        dec_cnt;
	reg  [5:0]        bit_cnt;
	reg  [5:0]        fsi_cnt;
	reg               fsi_prev;
	reg  [WORD_W-1:0] fsi_shift;
	reg  [2:0]        sync_cnt;
	reg               sync_fall_q;
	reg               sync_q;
	reg  [31:0]       next_prdata;
	reg               word_pend;
	wire              sco_rise;
	wire              sco_fall;
	wire              run;
	wire              restart;
	wire [9:0]        dec_len;
	wire              wr;
	wire              rd;
	wire              frame_start;
	wire              frame_end;
	wire              fsi_done;
	wire              fsi_low;
	wire              fsi_run_full;
	wire              sync_full;
	wire              ctrl_sel;
	wire              stat_sel;
	wire              word_sel;
	wire              fsi_sel;
	wire              fsi_clr;
	// Sleep pin or software halt stops the divider, decimation, frames and frame-sync input
	assign run     = sleep_pin_n & ctrl[`ADCSF_CTRL_RUN]; // [R15]
	assign restart = ~run | sync_q;
	assign dec_len = ctrl[`ADCSF_CTRL_DEC256] ? `ADCSF_DEC_HI : `ADCSF_DEC_LO;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign serial_clock_out = modulator_clock; // [R2]

	adcsf_clkdiv u_div (
		.pclk            (pclk),
		.presetn         (presetn),
		.restart         (restart),
		.modulator_clock (modulator_clock),
		.sco_rise        (sco_rise),
		.sco_fall        (sco_fall)
	);

	// Decimation counter in modulator clock periods
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_cnt   <= 10'd0; // [R17]
			word_pend <= 1'b0;
		end else if (restart) begin
			dec_cnt   <= 10'd0;
			word_pend <= 1'b0;
		end else if (sco_rise) begin
			if (dec_cnt == dec_len - 10'd1) begin
				dec_cnt   <= 10'd0;
				word_pend <= 1'b1; // [R3]
			end else begin
				dec_cnt <= dec_cnt + 10'd1;
				if (frame_start)
					word_pend <= 1'b0;
			end
		end
	end

	assign frame_start = sco_rise & word_pend & frame_sync_out;
	assign frame_end   = sco_rise & ~frame_sync_out & (bit_cnt == `ADCSF_FRAME_BITS - 6'd1);

	// Output frame: low for exactly 32 serial clock periods
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_out <= 1'b1;
			bit_cnt        <= 6'd0;
		end else if (restart) begin
			frame_sync_out <= 1'b1; // [R15]
			bit_cnt        <= 6'd0;
		end else if (frame_start) begin
			frame_sync_out <= 1'b0; // [R4]
			bit_cnt        <= 6'd0;
		end else if (frame_end) begin
			frame_sync_out <= 1'b1; // [R8]
		end else if (sco_rise & ~frame_sync_out) begin
			bit_cnt <= bit_cnt + 6'd1;
		end
	end

	adcsf_shifter #(
		.WIDTH (WORD_W)
	) u_sh (
		.pclk            (pclk),
		.presetn         (presetn),
		.load            (frame_start),
		.shift           (sco_rise & ~frame_sync_out),
		.stop            (restart | frame_end),
		.word            (conv_word),
		.serial_data_out (serial_data_out),
		.sdo_oe          (serial_data_out_oe)
	);

	// Frame-sync input and serial input taken on serial clock falls
	// A run ends on a high sample or after a full word of 32 bits
	assign fsi_low      = ~frame_sync_in;
	assign fsi_run_full = (fsi_cnt == `ADCSF_FRAME_BITS);
	assign fsi_done     = sco_fall & ~fsi_prev & (~fsi_low | fsi_run_full); // [R9]
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsi_prev  <= 1'b1;
			fsi_cnt   <= 6'd0;
			fsi_shift <= {WORD_W{1'b0}};
		end else if (restart) begin
			fsi_prev  <= 1'b1;
			fsi_cnt   <= 6'd0;
		end else if (sco_fall) begin
			fsi_prev <= frame_sync_in | fsi_done; // [R9]
			if (!frame_sync_in && !fsi_done) begin
				fsi_shift <= {fsi_shift[WORD_W-2:0], serial_data_in};
				fsi_cnt   <= fsi_prev ? 6'd1 : fsi_cnt + 6'd1;
			end
		end
	end

	// Sync level taken on master clock falls
	always @(negedge pclk or negedge presetn) begin
		if (!presetn)
			sync_fall_q <= 1'b1;
		else
			sync_fall_q <= sync_n; // [R14]
	end

	assign sync_full = (sync_cnt == `ADCSF_SYNC_MIN);

	// Sync pulse: low run counted, release accepted after four clocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_cnt  <= 3'd0;
			sync_q    <= 1'b0;
			sync_done <= 1'b0;
		end else if (!sync_fall_q) begin
			sync_q    <= 1'b0;
			sync_done <= 1'b0;
			if (!sync_full)
				sync_cnt <= sync_cnt + 3'd1;
		end else begin
			sync_cnt  <= 3'd0;
			sync_q    <= sync_full; // [R14]
			sync_done <= sync_full;
		end
	end

	// Register decode
	assign ctrl_sel = (paddr == `ADCSF_CTRL_OFS);
	assign stat_sel = (paddr == `ADCSF_STAT_OFS);
	assign word_sel = (paddr == `ADCSF_WORD_OFS);
	assign fsi_sel  = (paddr == `ADCSF_FSI_OFS);
	assign fsi_clr  = wr & stat_sel & pwdata[`ADCSF_STAT_FSIRX];

	// Control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= `ADCSF_CTRL_RST; // [R12]
		else if (wr & ctrl_sel)
			ctrl <= pwdata[2:0];
	end

	// Word to send; a write meeting a frame start stays pending
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_word  <= {WORD_W{1'b0}};
			word_ready <= 1'b0;
		end else if (wr & word_sel) begin
			conv_word  <= pwdata[WORD_W-1:0];
			word_ready <= 1'b1;
		end else if (frame_start) begin
			word_ready <= 1'b0;
		end
	end

	// Received input word; capture wins over a clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsi_word <= {WORD_W{1'b0}};
			fsi_rx   <= 1'b0;
		end else if (fsi_done) begin
			fsi_word <= fsi_shift; // [R9]
			fsi_rx   <= 1'b1;
		end else if (fsi_clr) begin
			fsi_rx <= 1'b0;
		end
	end

	// Read data chosen in the setup cycle
	always @* begin
		next_prdata = 32'h0000_0000;
		if (ctrl_sel) begin
			next_prdata[2:0] = ctrl;
		end else if (stat_sel) begin
			next_prdata[`ADCSF_STAT_FRAME]   = ~frame_sync_out;
			next_prdata[`ADCSF_STAT_SLEEP]   = ~sleep_pin_n;
			next_prdata[`ADCSF_STAT_WORDRDY] = word_ready;
			next_prdata[`ADCSF_STAT_FSIRX]   = fsi_rx;
		end else if (word_sel) begin
			next_prdata[WORD_W-1:0] = conv_word;
		end else if (fsi_sel) begin
			next_prdata[WORD_W-1:0] = fsi_word;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd)
			prdata <= next_prdata;
	end
endmodule // adcsf_frame

// ===== inc/adcsf_map.vh
// Address map, field positions, reset values and timing counts for the frame timing block
`ifndef ADCSF_MAP_VH
`define ADCSF_MAP_VH
`define ADCSF_CTRL_OFS      12'h000
`define ADCSF_STAT_OFS      12'h004
`define ADCSF_WORD_OFS      12'h008
`define ADCSF_FSI_OFS       12'h00c
`define ADCSF_CTRL_RUN      0
`define ADCSF_CTRL_DEC256   1
`define ADCSF_CTRL_SYNC     2
`define ADCSF_CTRL_RST      3'h1
`define ADCSF_STAT_FRAME    0
`define ADCSF_STAT_SLEEP    1
`define ADCSF_STAT_WORDRDY  2
`define ADCSF_STAT_FSIRX    3
`define ADCSF_DEC_LO        10'd128
`define ADCSF_DEC_HI        10'd256
`define ADCSF_FRAME_BITS    6'd32
`define ADCSF_SYNC_MIN      3'd4
`endif

// ===== verilog/adcsf_clkdiv.v
// Halving divider that makes the modulator clock and serial clock level
`timescale 1ns/10ps
module adcsf_clkdiv (
	input  wire pclk,
	input  wire presetn,
	input  wire restart,
	output reg  modulator_clock,
	output wire sco_rise,
	output wire sco_fall
);
	// One pclk high, one pclk low: period is two master clocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			modulator_clock <= 1'b0;
		else if (restart)
			modulator_clock <= 1'b0;
		else
			modulator_clock <= ~modulator_clock; // [R2]
	end
	assign sco_rise = ~modulator_clock & ~restart;
	assign sco_fall = modulator_clock & ~restart;
endmodule // adcsf_clkdiv

// ===== verilog/adcsf_shifter.v
// Serial word shifter, MSB first, with driver enable
`timescale 1ns/10ps
module adcsf_shifter #(
	parameter WIDTH = 32
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             load,
	input  wire             shift,
	input  wire             stop,
	input  wire [WIDTH-1:0] word,
	output wire             serial_data_out,
	output reg              sdo_oe
);
	reg [WIDTH-1:0] sreg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sreg   <= {WIDTH{1'b0}};
			sdo_oe <= 1'b0;
		end else if (stop) begin
			sreg   <= {WIDTH{1'b0}};
			sdo_oe <= 1'b0; // [R16]
		end else if (load) begin
			sreg   <= word; // [R6]
			sdo_oe <= 1'b1; // [R5]
		end else if (shift) begin
			sreg <= {sreg[WIDTH-2:0], 1'b0}; // [R7]
		end
	end
	assign serial_data_out = sreg[WIDTH-1];
endmodule // adcsf_shifter

// ===== verif/adcsf_monitor.sv
// Checker of frame timing at the block's ports
`timescale 1ns/10ps
module adcsf_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sleep_pin_n,
	input wire logic serial_clock_out,
	input wire logic frame_sync_out,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sco_pulse_a: assert property ($rose(serial_clock_out) |=> !serial_clock_out)
		else $error("serial clock high too long");
	fso_fall_a: assert property ($fell(frame_sync_out) |-> $rose(serial_clock_out))
		else $error("frame start off serial clock rise");
	oe_on_a: assert property ($fell(frame_sync_out) |-> $rose(serial_data_out_oe))
		else $error("driver not enabled at frame start");
	fso_rise_a: assert property ($rose(frame_sync_out) |-> $rose(serial_clock_out))
		else $error("frame end off serial clock rise");
	fso_len_a: assert property ($fell(frame_sync_out) |-> ##64 $rose(frame_sync_out))
		else $error("frame length wrong");
	oe_idle_a: assert property (frame_sync_out |-> !serial_data_out_oe)
		else $error("data driven between frames");
	bit_step_a: assert property (serial_data_out_oe && $changed(serial_data_out)
		|-> $rose(serial_clock_out))
		else $error("data moved off serial clock rise");
	sleep_halt_a: assert property (!sleep_pin_n [*3] |-> !$fell(frame_sync_out))
		else $error("frame started while asleep");
endmodule // adcsf_monitor

// ===== verif/adcsf_host.sv
// Host serial port model facing the frame timing block
`timescale 1ns/10ps
module adcsf_host (
	input  wire        pclk,
	input  wire        serial_clock_out,
	input  wire        frame_sync_out,
	input  wire        serial_data_out,
	input  wire        send,
	input  wire [31:0] tx_word,
	output reg         frame_sync_in,
	output reg         serial_data_in,
	output reg  [31:0] rx_word
);
	reg [5:0] tx_left;
	initial begin
		frame_sync_in = 1'b1;
		serial_data_in = 1'b0;
		rx_word = 32'h0;
		tx_left = 6'h00;
	end
	always @(posedge pclk) begin
		if (serial_clock_out && !frame_sync_out)
			rx_word <= {rx_word[30:0], serial_data_out};
		if (send)
			tx_left <= 6'd32;
		else if (!serial_clock_out) begin // Change on serial rise, stable at fall
			frame_sync_in <= (tx_left == 6'h00); // Low for 32 periods
			serial_data_in <= (tx_left != 6'h00) ? tx_word[tx_left - 6'h01] : ~serial_data_in;
			if (tx_left != 6'h00)
				tx_left <= tx_left - 6'h01;
		end
	end
endmodule // adcsf_host

// ===== verif/adcsf_frame_tb_top.sv
// Bench for the frame timing block
`timescale 1ns/10ps
module adcsf_frame_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, sleep_pin_n, sync_n, send;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rx_word, tx_word, rd;
	wire         pready, pslverr, modulator_clock, serial_clock_out, frame_sync_out;
	wire         serial_data_out, serial_data_out_oe, sync_done, frame_sync_in, serial_data_in;
	int          n_errors, checked, cycles, t0, t1;
	adcsf_frame u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_pin_n(sleep_pin_n), .sync_n(sync_n),
		.frame_sync_in(frame_sync_in), .serial_data_in(serial_data_in),
		.modulator_clock(modulator_clock), .serial_clock_out(serial_clock_out),
		.frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe), .sync_done(sync_done));
	adcsf_host u_host (.pclk(pclk), .serial_clock_out(serial_clock_out),
		.frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out), .send(send),
		.tx_word(tx_word), .frame_sync_in(frame_sync_in), .serial_data_in(serial_data_in),
		.rx_word(rx_word));
	always #12.5 pclk = ~pclk;
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		chk("pslverr", pslverr, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic fso_edge(input logic lvl, output int t);
		@(negedge pclk);
		while (frame_sync_out !== ~lvl) @(negedge pclk);
		while (frame_sync_out !== lvl) @(negedge pclk);
		t = cycles;
	endtask
	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sleep_pin_n = 1;
		sync_n = 1;
		send = 0;
		tx_word = 32'h0;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(posedge pclk);
		chk("oe in reset", serial_data_out_oe, 32'h0);
		chk("modclk in reset", modulator_clock, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, 12'h008, 32'hc35a_0f96);
		fso_edge(1'b0, t0);
		chk("first frame", 32'(t0), 32'd261);
		fso_edge(1'b1, t0);
		chk("word out", rx_word, 32'hc35a_0f96);
		fso_edge(1'b0, t0);
		fso_edge(1'b0, t1);
		chk("period 128", 32'(t1 - t0), 32'h100);
		apb(1'b1, 12'h000, 32'h3);
		fso_edge(1'b0, t0);
		fso_edge(1'b0, t0);
		fso_edge(1'b0, t1);
		chk("period 256", 32'(t1 - t0), 32'h200);
		@(posedge pclk);
		tx_word <= 32'h5a3c_96e1;
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
		@(negedge frame_sync_in);
		@(posedge frame_sync_in);
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h00c, 32'h0);
		chk("fsi word", rd, 32'h5a3c_96e1);
		apb(1'b0, 12'h004, 32'h0);
		chk("fsi flag", {31'h0, rd[3]}, 32'h1);
		apb(1'b1, 12'h004, 32'h8);
		apb(1'b0, 12'h004, 32'h0);
		chk("fsi clear", {31'h0, rd[3]}, 32'h0);
		fso_edge(1'b1, t0);
		@(posedge pclk);
		sleep_pin_n <= 1'b0;
		repeat (600) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("sleeping", {31'h0, rd[1]}, 32'h1);
		chk("no frame asleep", frame_sync_out, 32'h1);
		sleep_pin_n <= 1'b1;
		sync_n <= 1'b0;
		repeat (4) @(posedge pclk);
		sync_n <= 1'b1;
		@(negedge pclk);
		chk("sync early", sync_done, 32'h0);
		@(negedge pclk);
		chk("sync done", sync_done, 32'h1);
		t0 = cycles;
		fso_edge(1'b0, t1);
		chk("sync to frame", 32'(t1 - t0), 32'd514);
		fso_edge(1'b0, t0);
		chk("period after sync", 32'(t0 - t1), 32'h200);
		end_sim();
	end
endmodule // adcsf_frame_tb_top
bind adcsf_frame adcsf_monitor u_mon (.pclk(pclk), .presetn(presetn),
	.sleep_pin_n(sleep_pin_n), .serial_clock_out(serial_clock_out),
	.frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out),
	.serial_data_out_oe(serial_data_out_oe));
